/* File: slc_swing_length_count.sv */
`include "slc_cfg.svh"
module slc_swing_length_count
	import slc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `SLC_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Central frequency from the frequency source, 0.01 Hz units.
	input wire logic [15:0] center_freq_i,
	// Digital input terminals.
	input wire logic length_pulse_i,
	input wire logic count_pulse_i,
	input wire logic length_reset_i,
	// Output frequency and digital output terminals.
	output logic [15:0] freq_out_o,
	output logic length_reached_o,
	output logic count_final_o,
	output logic count_intermediate_o,
	output logic irq_o
);
	// ****************************************
	// Input terminals
	// ****************************************
	slc_pin_if pin ();
	assign pin.raw = {length_reset_i, count_pulse_i, length_pulse_i};
	slc_pin_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pins(pin.sync)
	);

	// ****************************************
	// Register bus
	// ****************************************
	localparam logic [31:0] CFG_RST [`SLC_CFG_WORDS] = '{`SLC_RST_CTRL, `SLC_RST_SWING, `SLC_RST_TIMING,
		`SLC_RST_FREQ, `SLC_RST_LIMITS, `SLC_RST_LEN_CFG, `SLC_RST_CNT_CFG, `SLC_RST_IRQ_MASK};
	localparam logic [31:0] CFG_WM [`SLC_CFG_WORDS] = '{`SLC_WM_CTRL, `SLC_WM_SWING, `SLC_WM_TIMING,
		`SLC_WM_FREQ, `SLC_WM_FULL, `SLC_WM_FULL, `SLC_WM_FULL, `SLC_WM_IRQ};

	logic [31:0] cfg_reg [`SLC_CFG_WORDS];
	logic [31:0] cfg_next [`SLC_CFG_WORDS];
	logic [2:0] irq_st_reg, irq_st_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic req, wr;
	logic [7:0] off;
	logic [31:0] wmerge, rd_mux;
	logic cnt_clr, len_clr;
	logic [2:0] events;

	slc_freq_t aw, freq_reg, measured_reg;
	logic [15:0] count_reg;
	logic len_hit_reg, final_hit_reg, inter_hit_reg;

	assign req = wb_cyc_i & wb_stb_i;
	assign wr = req & wb_we_i & ack_reg;
	assign off = {wb_adr_i[7:2], 2'b00};
	assign wmerge = slc_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
	assign cnt_clr = wr && off == `SLC_OFF_CTRL && wmerge[`SLC_F_CNT_CLR];
	assign len_clr = (wr && off == `SLC_OFF_CTRL && wmerge[`SLC_F_LEN_CLR]) || pin.level[2];

	always_comb begin
		unique case (off)
			`SLC_OFF_CTRL, `SLC_OFF_SWING, `SLC_OFF_TIMING, `SLC_OFF_FREQ, `SLC_OFF_LIMITS,
			`SLC_OFF_LEN_CFG, `SLC_OFF_CNT_CFG, `SLC_OFF_IRQ_MASK: rd_mux = cfg_reg[off[4:2]];
			`SLC_OFF_LEN_STAT: rd_mux = {16'h0000, measured_reg};
			`SLC_OFF_CNT_STAT: rd_mux = {16'h0000, count_reg};
			`SLC_OFF_FREQ_STAT: rd_mux = {aw, freq_reg};
			`SLC_OFF_IRQ_STAT: rd_mux = {29'h0000_0000, irq_st_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		ack_next = req & ~ack_reg;
		dat_next = (req & ~ack_reg) ? rd_mux : dat_reg;
		for (int i = 0; i < `SLC_CFG_WORDS; i++) begin
			cfg_next[i] = cfg_reg[i];
			if (wr && off == 8'(i * 4)) begin
				cfg_next[i] = slc_merge(cfg_reg[i], wb_dat_i, wb_sel_i) & CFG_WM[i];
			end
		end
		irq_st_next = irq_st_reg;
		if (wr && off == `SLC_OFF_IRQ_STAT) begin
			irq_st_next = irq_st_reg & ~wmerge[2:0];
		end
		irq_st_next = irq_st_next | events;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			irq_st_reg <= 3'h0;
			for (int i = 0; i < `SLC_CFG_WORDS; i++) begin
				cfg_reg[i] <= CFG_RST[i];
			end
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			irq_st_reg <= irq_st_next;
			cfg_reg <= cfg_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq_o = |(irq_st_reg & cfg_reg[7][2:0]);

	// ****************************************
	// Swing generator
	// ****************************************
	slc_phase_e phase_reg, phase_next;
	logic [21:0] pos_reg, pos_next;
	logic [16:0] tick_cnt_reg, tick_cnt_next;
	slc_freq_t freq_next, base_freq, jump, lower, upper;
	logic tick;
	logic [14:0] cyc_time;
	logic [9:0] coef;
	logic [21:0] total_t, rise_t, seg_t;
	logic [17:0] span, ramp;
	logic signed [19:0] offset, fsum;

	assign tick = tick_cnt_reg == 17'(TICK_CYCLES - 1);
	assign lower = cfg_reg[4][`SLC_F_LOWER];
	assign upper = cfg_reg[4][`SLC_F_UPPER];

	always_comb begin
		base_freq = cfg_reg[0][`SLC_F_BASE_SEL] ? cfg_reg[3][`SLC_F_MAX_FREQ] : center_freq_i;
		aw = slc_pct_of(base_freq, cfg_reg[1][`SLC_F_SWING_AMP], `SLC_SWING_PCT_MAX);
		jump = slc_pct_of(aw, cfg_reg[1][`SLC_F_JUMP_AMP], `SLC_JUMP_PCT_MAX);
		cyc_time = (cfg_reg[2][`SLC_F_CYCLE] > `SLC_CYCLE_MAX) ? `SLC_CYCLE_MAX : cfg_reg[2][`SLC_F_CYCLE];
		coef = (cfg_reg[2][`SLC_F_RISE_COEF] > `SLC_PCT_FULL) ? `SLC_PCT_FULL : cfg_reg[2][`SLC_F_RISE_COEF];
		total_t = 22'(cyc_time * `SLC_CYCLE_UNIT_TICKS);
		rise_t = 22'((32'(cyc_time) * `SLC_CYCLE_UNIT_TICKS * 32'(coef)) / 32'(`SLC_PCT_FULL));
		seg_t = (phase_reg == SLC_RISE) ? rise_t : total_t - rise_t;
		span = {1'b0, aw, 1'b0} - {2'b00, jump};
		ramp = (seg_t == 22'h0) ? 18'h0 : 18'((40'(span) * 40'(pos_reg)) / 40'(seg_t));
		// Each segment starts one jump inward of the turning point it leaves; the ramp spans the rest.
		if (phase_reg == SLC_RISE) begin
			offset = 20'(jump) - 20'(aw) + 20'(ramp);
		end else begin
			offset = 20'(aw) - 20'(jump) - 20'(ramp);
		end
		if (aw == 16'h0) begin
			offset = 20'sh0;
		end
		// Signed compares, so that a swing that dips below zero clamps to the lower limit.
		fsum = $signed({4'h0, center_freq_i}) + offset;
		if (fsum > $signed({4'h0, upper})) begin
			freq_next = upper;
		end else if (fsum < $signed({4'h0, lower})) begin
			freq_next = lower;
		end else begin
			freq_next = fsum[15:0];
		end
		if (!tick) begin
			freq_next = freq_reg;
		end
	end

	always_comb begin
		tick_cnt_next = tick ? 17'h0 : tick_cnt_reg + 17'h1;
		phase_next = phase_reg;
		pos_next = pos_reg;
		if (tick) begin
			if (aw == 16'h0 || total_t == 22'h0) begin
				phase_next = SLC_RISE;
				pos_next = 22'h0;
			end else if (pos_reg + 22'h1 >= seg_t) begin
				pos_next = 22'h0;
				unique case (phase_reg)
					SLC_RISE: phase_next = SLC_FALL;
					SLC_FALL: phase_next = SLC_RISE;
				endcase
			end else begin
				pos_next = pos_reg + 22'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_reg <= 17'h0;
			phase_reg <= SLC_RISE;
			pos_reg <= 22'h0;
			freq_reg <= 16'h0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			phase_reg <= phase_next;
			pos_reg <= pos_next;
			freq_reg <= freq_next;
		end
	end

	assign freq_out_o = freq_reg;

	// ****************************************
	// Length and count
	// ****************************************
	logic [31:0] pulse_reg, pulse_next;
	logic [35:0] len_quot;
	slc_freq_t measured_next, count_next, ppm;
	logic len_hit_next, final_hit_next, inter_hit_next;

	always_comb begin
		ppm = cfg_reg[5][`SLC_F_PPM];
		pulse_next = pulse_reg;
		if (len_clr) begin
			pulse_next = 32'h0;
		end else if (pin.rise[0] && pulse_reg != 32'hffff_ffff) begin
			pulse_next = pulse_reg + 32'h1;
		end
		len_quot = (ppm == 16'h0) ? 36'h0 : ({4'h0, pulse_reg} * `SLC_PPM_SCALE) / 36'(ppm);
		measured_next = (len_quot > 36'(`SLC_LEN_MAX)) ? `SLC_LEN_MAX : len_quot[15:0];
		len_hit_next = measured_reg > cfg_reg[5][`SLC_F_TARGET_LEN];
		final_hit_next = count_reg >= cfg_reg[6][`SLC_F_FINAL];
		inter_hit_next = count_reg >= cfg_reg[6][`SLC_F_INTER];
		count_next = count_reg;
		if (cnt_clr) begin
			count_next = 16'h0;
		end else if (pin.rise[1] && !final_hit_next) begin
			count_next = count_reg + 16'h1;
		end
		events = {inter_hit_next & ~inter_hit_reg, final_hit_next & ~final_hit_reg, len_hit_next & ~len_hit_reg};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_reg <= 32'h0;
			measured_reg <= 16'h0;
			count_reg <= 16'h0;
			len_hit_reg <= 1'b0;
			final_hit_reg <= 1'b0;
			inter_hit_reg <= 1'b0;
		end else begin
			pulse_reg <= pulse_next;
			measured_reg <= measured_next;
			count_reg <= count_next;
			len_hit_reg <= len_hit_next;
			final_hit_reg <= final_hit_next;
			inter_hit_reg <= inter_hit_next;
		end
	end

	assign length_reached_o = len_hit_reg;
	assign count_final_o = final_hit_reg;
	assign count_intermediate_o = inter_hit_reg;

	// ****************************************
	// Checks
	// ****************************************
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_reg |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus request not answered in one cycle.");
	swing_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && cfg_reg[1][`SLC_F_SWING_AMP] == 10'h0 && center_freq_i >= lower && center_freq_i <= upper
		|=> freq_out_o == $past(center_freq_i))
		else $error("Zero amplitude still swings the output.");
	freq_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && lower <= upper |=> freq_out_o <= $past(upper) && freq_out_o >= $past(lower))
		else $error("Output frequency outside its limits.");
	fixed_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_reg[0][`SLC_F_BASE_SEL] |-> aw == slc_pct_of(cfg_reg[3][`SLC_F_MAX_FREQ],
		cfg_reg[1][`SLC_F_SWING_AMP], `SLC_SWING_PCT_MAX))
		else $error("Fixed amplitude not based on maximum frequency.");
	rise_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && aw != 16'h0 && phase_reg == SLC_RISE && rise_t != 22'h0 && rise_t != total_t
		&& pos_reg + 22'h1 == rise_t |=> phase_reg == SLC_FALL && pos_reg == 22'h0)
		else $error("Rise segment length wrong.");
	len_reached_a: assert property (@(posedge clk_i) disable iff (rst_i)
		measured_reg > cfg_reg[5][`SLC_F_TARGET_LEN] |=> length_reached_o)
		else $error("Length reached not signalled.");
	len_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pin.level[2] |=> pulse_reg == 32'h0 ##2 measured_reg == 16'h0 || $past(pulse_reg) != 32'h0)
		else $error("Length reset did not clear the length.");
	count_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		final_hit_next && !cnt_clr |=> $stable(count_reg) ##0 count_final_o)
		else $error("Counter kept counting past the final threshold.");
	count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pin.rise[1] && !final_hit_next && !cnt_clr |=> count_reg == $past(count_reg) + 16'h1)
		else $error("Counter missed a pulse.");
	inter_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		count_reg >= cfg_reg[6][`SLC_F_INTER] |=> count_intermediate_o)
		else $error("Intermediate threshold not signalled.");
	irq_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
		events[0] |=> irq_st_reg[0])
		else $error("Event did not set its status bit.");
endmodule

/* File: slc_cfg.svh */
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH
// Summary of operation
// - Output frequency swings above and below the central frequency as its midpoint.
// - A zero swing amplitude setting gives zero amplitude and no swing.
// - Base select 0 uses central frequency; 1 uses maximum output frequency.
// - Actual swing amplitude is base frequency times swing percentage, 0.0 to 100.0.
// - Jump frequency is swing amplitude times jump percentage, 0.0 to 50.0.
// - Swinging output is clamped between the frequency lower and upper limits.
// - One full swing cycle lasts the cycle time, 0.0 to 3000.0 s.
// - Rise time is cycle times coefficient; fall time is the remainder.
// - Measured length is counted length pulses divided by pulses per meter.
// - Length reached output turns on once measured length exceeds target length.
// - The length reset input clears the accumulated length pulses.
// - At the final count threshold the final output turns on and counting halts.
// - At the intermediate threshold its output turns on and counting continues.

// ****************************************
// Timing
// ****************************************
`define SLC_CLK_MHZ 100
`define SLC_TICK_US 1000
`define SLC_TICK_CYCLES (`SLC_TICK_US * `SLC_CLK_MHZ)
`define SLC_TICK_MS 1
`define SLC_CYCLE_UNIT_MS 100
`define SLC_CYCLE_UNIT_TICKS (`SLC_CYCLE_UNIT_MS / `SLC_TICK_MS)

// ****************************************
// Scales and limits
// ****************************************
`define SLC_PCT_FULL 10'd1000
`define SLC_SWING_PCT_MAX 10'd1000
`define SLC_JUMP_PCT_MAX 10'd500
`define SLC_CYCLE_MAX 15'd30000
`define SLC_PPM_SCALE 36'd10
`define SLC_LEN_MAX 16'hffff

// ****************************************
// Register word offsets
// ****************************************
`define SLC_OFF_CTRL 8'h00
`define SLC_OFF_SWING 8'h04
`define SLC_OFF_TIMING 8'h08
`define SLC_OFF_FREQ 8'h0c
`define SLC_OFF_LIMITS 8'h10
`define SLC_OFF_LEN_CFG 8'h14
`define SLC_OFF_CNT_CFG 8'h18
`define SLC_OFF_IRQ_MASK 8'h1c
`define SLC_OFF_LEN_STAT 8'h20
`define SLC_OFF_CNT_STAT 8'h24
`define SLC_OFF_FREQ_STAT 8'h28
`define SLC_OFF_IRQ_STAT 8'h2c
`define SLC_CFG_WORDS 8

// ****************************************
// Fields
// ****************************************
`define SLC_F_BASE_SEL 0
`define SLC_F_CNT_CLR 1
`define SLC_F_LEN_CLR 2
`define SLC_F_SWING_AMP 9:0
`define SLC_F_JUMP_AMP 25:16
`define SLC_F_CYCLE 14:0
`define SLC_F_RISE_COEF 25:16
`define SLC_F_MAX_FREQ 15:0
`define SLC_F_LOWER 15:0
`define SLC_F_UPPER 31:16
`define SLC_F_TARGET_LEN 15:0
`define SLC_F_PPM 31:16
`define SLC_F_FINAL 15:0
`define SLC_F_INTER 31:16
`define SLC_IRQ_LEN 0
`define SLC_IRQ_FINAL 1
`define SLC_IRQ_INTER 2

// ****************************************
// Reset values and write masks
// ****************************************
`define SLC_RST_CTRL 32'h0000_0000
`define SLC_RST_SWING 32'h01f4_0000
`define SLC_RST_TIMING 32'h01f4_0064
`define SLC_RST_FREQ 32'h0000_1388
`define SLC_RST_LIMITS 32'h1388_0000
`define SLC_RST_LEN_CFG 32'h03e8_03e8
`define SLC_RST_CNT_CFG 32'h03e8_03e8
`define SLC_RST_IRQ_MASK 32'h0000_0000
`define SLC_WM_CTRL 32'h0000_0001
`define SLC_WM_SWING 32'h03ff_03ff
`define SLC_WM_TIMING 32'h03ff_7fff
`define SLC_WM_FREQ 32'h0000_ffff
`define SLC_WM_FULL 32'hffff_ffff
`define SLC_WM_IRQ 32'h0000_0007
`endif

/* File: slc_pkg.sv */
`include "slc_cfg.svh"
package slc_pkg;
	typedef enum logic [0:0] {
		SLC_RISE = 1'b0,
		SLC_FALL = 1'b1
	} slc_phase_e;

	typedef logic [15:0] slc_freq_t;

	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] slc_merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Percentage in 0.1 % steps of a frequency, with the percentage capped.
	function automatic slc_freq_t slc_pct_of(input slc_freq_t base, input logic [9:0] pct,
		input logic [9:0] lim);
		logic [9:0] p;
		logic [25:0] prod;
		p = (pct > lim) ? lim : pct;
		prod = base * p;
		return 16'(prod / 26'(`SLC_PCT_FULL));
	endfunction
endpackage

/* File: slc_pin_if.sv */
interface slc_pin_if;
	logic [2:0] raw;
	logic [2:0] level;
	logic [2:0] rise;
	modport sync (input raw, output level, output rise);
	modport user (output raw, input level, input rise);
endinterface

/* File: slc_pin_sync.sv */
module slc_pin_sync (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Terminal levels in and filtered levels out.
	slc_pin_if.sync pins
);
	// ****************************************
	// Three-stage synchroniser with agreement filter
	// ****************************************
	logic [2:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [2:0] s1_next, s2_next, s3_next, lvl_next;

	always_comb begin
		s1_next = pins.raw;
		s2_next = s1_reg;
		s3_next = s2_reg;
		lvl_next = lvl_reg;
		for (int i = 0; i < 3; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				lvl_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
			lvl_reg <= 3'h0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			lvl_reg <= lvl_next;
		end
	end

	assign pins.level = lvl_reg;
	assign pins.rise = lvl_next & ~lvl_reg;
endmodule

/* File: slc_sensor_model.sv */
module slc_sensor_model (
	// Clock.
	input wire logic clk_i,
	// Pulse terminals, idle low.
	output logic length_pulse_o,
	output logic count_pulse_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		length_pulse_o = 1'b0;
		count_pulse_o = 1'b0;
	end

	// Each level lasts four cycles so that the input filter never drops a pulse.
	task automatic send(input bit to_count, input int n);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge clk_i);
			if (to_count)
				count_pulse_o <= ~count_pulse_o;
			else
				length_pulse_o <= ~length_pulse_o;
			repeat (3) @(posedge clk_i);
		end
	endtask
endmodule

/* File: tb_slc_swing_length_count.sv */
`include "slc_cfg.svh"
module tb_slc_swing_length_count;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 10;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, length_reset_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic length_pulse, count_pulse, length_reached_o, count_final_o, count_intermediate_o, irq_o;
	logic [15:0] center_freq_i, freq_out_o, lo, hi;
	int failures, n_compared, period;

	slc_swing_length_count #(.TICK_CYCLES(TICK)) slc_swing_length_count_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .center_freq_i(center_freq_i),
		.length_pulse_i(length_pulse), .count_pulse_i(count_pulse), .length_reset_i(length_reset_i),
		.freq_out_o(freq_out_o), .length_reached_o(length_reached_o), .count_final_o(count_final_o),
		.count_intermediate_o(count_intermediate_o), .irq_o(irq_o));

	slc_sensor_model slc_sensor_model_i (
		.clk_i(clk_i), .length_pulse_o(length_pulse), .count_pulse_o(count_pulse));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One classic Wishbone cycle; read data lands in rd.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			give_verdict();
		end else begin
			rd = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
		end
	endtask

	task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check_val(rd, exp);
	endtask

	task automatic pulses(input bit to_count, input int n);
		slc_sensor_model_i.send(to_count, n);
		repeat (8) @(posedge clk_i);
	endtask

	task automatic swing_run(input int n);
		int t_last;
		logic [15:0] prev;
		lo = 16'hffff;
		hi = 16'h0;
		t_last = 0;
		prev = freq_out_o;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			if (freq_out_o < lo)
				lo = freq_out_o;
			if (freq_out_o > hi)
				hi = freq_out_o;
			if (freq_out_o === 16'h041a && prev !== 16'h041a) begin
				period = i - t_last;
				t_last = i;
			end
			prev = freq_out_o;
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic reset_values();
		rchk(`SLC_OFF_SWING, `SLC_RST_SWING);
		rchk(`SLC_OFF_TIMING, `SLC_RST_TIMING);
		rchk(`SLC_OFF_LEN_CFG, `SLC_RST_LEN_CFG);
		rchk(`SLC_OFF_CNT_CFG, `SLC_RST_CNT_CFG);
		wb(1'b1, `SLC_OFF_CNT_STAT, 32'hffff_ffff);
		rchk(`SLC_OFF_CNT_STAT, 32'h0);
		rchk(8'h3c, 32'h0);
	endtask

	task automatic count_test();
		wb(1'b1, `SLC_OFF_CNT_CFG, 32'h0003_0005);
		pulses(1'b1, 2);
		check_val({31'h0, count_intermediate_o}, 32'h0);
		pulses(1'b1, 1);
		check_val({31'h0, count_intermediate_o}, 32'h1);
		check_val({31'h0, count_final_o}, 32'h0);
		check_val({31'h0, irq_o}, 32'h0);
		rchk(`SLC_OFF_IRQ_STAT, 32'h4);
		wb(1'b1, `SLC_OFF_IRQ_MASK, 32'h7);
		repeat (2) @(posedge clk_i);
		check_val({31'h0, irq_o}, 32'h1);
		wb(1'b1, `SLC_OFF_IRQ_STAT, 32'h4);
		repeat (2) @(posedge clk_i);
		check_val({31'h0, irq_o}, 32'h0);
		pulses(1'b1, 4);
		check_val({31'h0, count_final_o}, 32'h1);
		check_val({31'h0, irq_o}, 32'h1);
		rchk(`SLC_OFF_CNT_STAT, 32'h5);
		wb(1'b1, `SLC_OFF_CTRL, 32'h2);
		rchk(`SLC_OFF_CNT_STAT, 32'h0);
		wb(1'b1, `SLC_OFF_IRQ_STAT, 32'h7);
	endtask

	task automatic length_test();
		wb(1'b1, `SLC_OFF_LEN_CFG, 32'h000a_0002);
		pulses(1'b0, 2);
		rchk(`SLC_OFF_LEN_STAT, 32'h2);
		check_val({31'h0, length_reached_o}, 32'h0);
		pulses(1'b0, 1);
		check_val({31'h0, length_reached_o}, 32'h1);
		length_reset_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		length_reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rchk(`SLC_OFF_LEN_STAT, 32'h0);
		wb(1'b1, `SLC_OFF_LEN_CFG, 32'h0014_0002);
		pulses(1'b0, 4);
		rchk(`SLC_OFF_LEN_STAT, 32'h2);
		wb(1'b1, `SLC_OFF_CTRL, 32'h4);
		wb(1'b1, `SLC_OFF_IRQ_STAT, 32'h7);
	endtask

	task automatic swing_test();
		wb(1'b1, `SLC_OFF_TIMING, 32'h01f4_0001);
		swing_run(300);
		check_val({lo, hi}, 32'h03e8_03e8);
		wb(1'b1, `SLC_OFF_LIMITS, 32'h041a_03b6);
		wb(1'b1, `SLC_OFF_SWING, 32'h0000_0064);
		swing_run(2500);
		check_val({16'h0, lo}, 32'h3b6);
		check_val({16'h0, hi}, 32'h41a);
		check_val(period, 100 * TICK);
		wb(1'b0, `SLC_OFF_FREQ_STAT, 32'h0);
		check_val({16'h0, rd[31:16]}, 32'd100);
		wb(1'b1, `SLC_OFF_CTRL, 32'h1);
		swing_run(3 * TICK);
		wb(1'b0, `SLC_OFF_FREQ_STAT, 32'h0);
		check_val({16'h0, rd[31:16]}, 32'd500);
		center_freq_i <= 16'h0000;
		repeat (2 * TICK) @(posedge clk_i);
		wb(1'b0, `SLC_OFF_FREQ_STAT, 32'h0);
		check_val({16'h0, rd[31:16]}, 32'd500);
		swing_run(110 * TICK);
		check_val({lo, hi}, 32'h03b6_03b6);
		center_freq_i <= 16'h03e8;
		wb(1'b1, `SLC_OFF_CTRL, 32'h0);
		wb(1'b1, `SLC_OFF_SWING, 32'h01f4_0064);
		wb(1'b1, `SLC_OFF_LIMITS, 32'h1388_0000);
		swing_run(110 * TICK);
		check_val({lo, hi}, 32'h0387_0449);
	endtask

	initial begin
		failures = 0;
		n_compared = 0;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		length_reset_i = 1'b0;
		center_freq_i = 16'h03e8;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		reset_values();
		count_test();
		length_test();
		swing_test();
		give_verdict();
	end
endmodule
